// ===== pis_init_sequencer.sv
// PSI5 power-up init sequencer with its output FIFO
`timescale 1ns/10ps

module pis_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wrPtr_q;
  logic [AW:0] rdPtr_q;
  logic full;
  logic empty;

  assign empty = wrPtr_q == rdPtr_q;
  assign full = (wrPtr_q[AW] != rdPtr_q[AW]) && (wrPtr_q[AW-1:0] == rdPtr_q[AW-1:0]);
  assign inReady = !full;
  assign outValid = !empty;
  assign outData = mem[rdPtr_q[AW-1:0]];

  always_ff @(posedge ref_clk) begin
    if (inValid && !full) begin
      mem[wrPtr_q[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wrPtr_q <= '0;
    end else if (inValid && !full) begin
      wrPtr_q <= wrPtr_q + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rdPtr_q <= '0;
    end else if (outReady && !empty) begin
      rdPtr_q <= rdPtr_q + 1'b1;
    end
  end
endmodule : pis_fifo

module pis_init_sequencer import pis_pkg::*; #(
  parameter int STAB_CYCLES = STAB_CYC,
  parameter int OC1_CYCLES = OC1_CYC,
  parameter int PME_CYCLES = PME_CYC,
  parameter int OC2_CYCLES = OC2_CYC,
  parameter int SLOT_CYCLES = ASYNC_PERIOD_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Link from the receiver
  input wire logic syncPulse,
  // Configuration
  input wire logic syncMode,
  input wire logic wordLen10,
  input wire logic lockUser,
  input wire logic selfTestPass,
  input wire logic [127:0] initData,
  // Word stream to the transmitter
  output logic txValid,
  input wire logic txReady,
  output pis_word_type txWord,
  // Status
  output logic outputSilent,
  output logic progMode,
  output logic phase2Active,
  output logic normalMode,
  output logic [15:0] phase2Words
);
  pis_state_type state_q;
  logic [31:0] timer_q;
  logic timerDone;
  logic [2:0] syncSh_q;
  logic syncEdge;
  logic [2:0] pmeCount_q;
  logic [31:0] slotTimer_q;
  logic slotTick;
  logic slotPend_q;
  logic fifoReady;
  logic fifoPush;
  logic wordAvail;
  pis_word_type pushWord;
  logic [4:0] field_q;
  logic [3:0] rep_q;
  logic sub_q;
  logic half_q;
  logic [3:0] repK;
  logic [5:0] lastField;
  logic lastWord;
  logic [3:0] nib;
  logic [15:0] sent_q;
  logic progOk;

  // ----------------------------------------
  // Sync pulse input
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      syncSh_q <= 3'h0;
    end else begin
      syncSh_q <= {syncSh_q[1:0], syncPulse};
    end
  end
  assign syncEdge = syncSh_q[1] && !syncSh_q[2];

  // ----------------------------------------
  // Phase timers
  // ----------------------------------------
  always_comb begin
    case (state_q)
      ST_STAB: timerDone = timer_q >= 32'(STAB_CYCLES - 1);
      ST_OC1: timerDone = timer_q >= 32'(OC1_CYCLES - 1);
      ST_PME: timerDone = timer_q >= 32'(PME_CYCLES - 1);
      ST_OC2: timerDone = timer_q >= 32'(OC2_CYCLES - 1);
      default: timerDone = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      timer_q <= '0;
    end else if (timerDone) begin
      timer_q <= '0;
    end else begin
      timer_q <= timer_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      pmeCount_q <= 3'h0;
    end else if (state_q == ST_PME && syncEdge && pmeCount_q != 3'h7) begin
      pmeCount_q <= pmeCount_q + 3'h1;
    end
  end
  // Lock is sampled when the decision falls, not at the pulses
  assign progOk = (pmeCount_q >= 3'(PME_PULSES)) && !lockUser;

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  // ordered phase 1
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_STAB;
    end else begin
      case (state_q)
        ST_STAB: if (timerDone) state_q <= ST_OC1;
        ST_OC1: if (timerDone) state_q <= ST_PME;
        ST_PME: if (timerDone) state_q <= ST_OC2;
        ST_OC2: if (timerDone) state_q <= progOk ? ST_PROG : ST_PH2;
        ST_PROG: state_q <= ST_PROG;
        ST_PH2: if (fifoPush && lastWord) state_q <= ST_BUSY;
        ST_BUSY: if (fifoPush) state_q <= ST_RESULT;
        ST_RESULT: if (fifoPush) state_q <= ST_NORMAL;
        ST_NORMAL: state_q <= ST_NORMAL;
        default: state_q <= ST_STAB;
      endcase
    end
  end

  // ----------------------------------------
  // Slot timing
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slotTimer_q <= '0;
    end else if (slotTimer_q >= 32'(SLOT_CYCLES - 1)) begin
      slotTimer_q <= '0;
    end else begin
      slotTimer_q <= slotTimer_q + 32'h0000_0001;
    end
  end
  assign slotTick = syncMode ? syncEdge : (slotTimer_q >= 32'(SLOT_CYCLES - 1));

  // one word per slot
  // Ticks outside word states are dropped; a tick in the cycle of a push wins and keeps the slot pending
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      slotPend_q <= 1'b0;
    end else if (slotTick && wordAvail) begin
      slotPend_q <= 1'b1;
    end else if (fifoPush) begin
      slotPend_q <= 1'b0;
    end
  end

  assign wordAvail = state_q == ST_PH2 || state_q == ST_BUSY || state_q == ST_RESULT;
  assign fifoPush = wordAvail && slotPend_q && fifoReady;

  // ----------------------------------------
  // Phase 2 framing
  // ----------------------------------------
  // repetition count
  assign repK = syncMode ? K_SYNC : K_ASYNC;
  assign lastField = (wordLen10 ? FIELDS_10 : FIELDS_8) - 6'h01;
  assign lastWord = sub_q && rep_q == repK - 4'h1 && {1'b0, field_q} == lastField
    && (wordLen10 || half_q);
  assign phase2Words = 16'(wordLen10 ? TRANS_10 : TRANS_8) * 16'(repK)
    * 16'(wordLen10 ? FIELDS_10 : FIELDS_8);

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sub_q <= 1'b0;
      rep_q <= 4'h0;
      half_q <= 1'b0;
      field_q <= 5'h00;
    end else if (fifoPush && state_q == ST_PH2) begin
      sub_q <= !sub_q;
      if (sub_q) begin
        if (rep_q == repK - 4'h1) begin
          rep_q <= 4'h0;
          half_q <= wordLen10 ? 1'b0 : !half_q;
          if (wordLen10 || half_q) begin
            field_q <= field_q + 5'h01;
          end
        end else begin
          rep_q <= rep_q + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sent_q <= 16'h0000;
    end else if (fifoPush && state_q == ST_PH2) begin
      sent_q <= sent_q + 16'h0001;
    end
  end

  // nibbles taken in order from the config/serial vector
  assign nib = initData[{field_q, 2'b00} +: 4];

  always_comb begin
    pushWord.kind = sub_q ? KIND_DATA : KIND_ID;
    pushWord.code = 10'h000;
    if (state_q == ST_BUSY) begin
      pushWord.kind = KIND_STATUS;
      pushWord.code = wordLen10 ? BUSY_10 : {2'b00, BUSY_8};
    end else if (state_q == ST_RESULT) begin
      pushWord.kind = KIND_STATUS;
      if (wordLen10) begin
        pushWord.code = selfTestPass ? READY_10 : DEFECT_10;
      end else begin
        pushWord.code = {2'b00, selfTestPass ? READY_8 : DEFECT_8};
      end
    end else if (wordLen10) begin
      pushWord.code = sub_q ? DATA_BASE_10 + {6'h00, nib} : ID_BASE_10 + {6'h00, field_q[3:0]};
    end else if (sub_q) begin
      pushWord.code = {2'b00, DATA_BASE_8 + {6'h00, half_q ? nib[1:0] : nib[3:2]}};
    end else begin
      pushWord.code = {2'b00, ID_BASE_8 + {6'h00, field_q[0], half_q}};
    end
  end

  // ----------------------------------------
  // Output buffer
  // ----------------------------------------
  // Full FIFO holds the slot, so a slow transmitter stalls the walk
  pis_fifo #(.WIDTH($bits(pis_word_type)), .DEPTH(16)) uFifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .inValid(fifoPush),
    .inReady(fifoReady),
    .inData(pushWord),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txWord)
  );

  assign outputSilent = state_q <= ST_PROG;
  assign progMode = state_q == ST_PROG;
  assign phase2Active = state_q == ST_PH2;
  assign normalMode = state_q == ST_NORMAL;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_silent;
    @(posedge ref_clk) disable iff (!rstn) state_q <= ST_PROG |-> !fifoPush;
  endproperty
  a_silent: assert property (p_silent) else $error("word pushed in phase 1");

  property p_order;
    @(posedge ref_clk) disable iff (!rstn) $changed(state_q) && state_q == ST_OC2 |-> $past(state_q) == ST_PME;
  endproperty
  a_order: assert property (p_order) else $error("offset stage 2 out of order");

  property p_prog;
    @(posedge ref_clk) disable iff (!rstn)
      state_q == ST_OC2 && timerDone |=> (state_q == ST_PROG) == $past(progOk);
  endproperty
  a_prog: assert property (p_prog) else $error("wrong entry decision");

  property p_locked;
    @(posedge ref_clk) disable iff (!rstn)
      state_q == ST_OC2 && timerDone && lockUser |=> state_q == ST_PH2;
  endproperty
  a_locked: assert property (p_locked) else $error("locked part left phase 1 badly");

  property p_id10;
    @(posedge ref_clk) disable iff (!rstn)
      fifoPush && state_q == ST_PH2 && wordLen10 && !sub_q |-> pushWord.code[9:4] == 6'h20;
  endproperty
  a_id10: assert property (p_id10) else $error("bad 10-bit ID code");

  property p_count;
    @(posedge ref_clk) disable iff (!rstn) $rose(state_q == ST_BUSY) |-> sent_q == phase2Words;
  endproperty
  a_count: assert property (p_count) else $error("phase 2 word count wrong");

  property p_k;
    @(posedge ref_clk) disable iff (!rstn)
      $rose(state_q == ST_BUSY) && wordLen10 |-> sent_q == (syncMode ? 16'h0100 : 16'h0200);
  endproperty
  a_k: assert property (p_k) else $error("10-bit repetition wrong");

  property p_busy;
    @(posedge ref_clk) disable iff (!rstn)
      state_q == ST_BUSY && fifoPush |=> state_q == ST_RESULT ##0 $past(pushWord.kind) == KIND_STATUS;
  endproperty
  a_busy: assert property (p_busy) else $error("busy word missing");

  property p_slot;
    @(posedge ref_clk) disable iff (!rstn) fifoPush |=> !fifoPush;
  endproperty
  a_slot: assert property (p_slot) else $error("two words in one slot");

  c_prog: cover property (@(posedge ref_clk) disable iff (!rstn) state_q == ST_PROG);
  c_norm10: cover property (@(posedge ref_clk) disable iff (!rstn) normalMode && wordLen10);
  c_norm8: cover property (@(posedge ref_clk) disable iff (!rstn) normalMode && !wordLen10);
  c_full: cover property (@(posedge ref_clk) disable iff (!rstn) wordAvail && !fifoReady);
endmodule : pis_init_sequencer

// ===== pis_init_sequencer_test.sv
// Testbench of the PSI5 init sequencer
`timescale 1ns/10ps

module pis_init_sequencer_test import pis_pkg::*;;
  logic ref_clk, rstn, syncPulse, syncMode, wordLen10, lockUser, selfTestPass;
  logic txValid, txReady, outputSilent, progMode, phase2Active, normalMode, syncOn;
  logic [15:0] phase2Words, stallLen;
  logic [127:0] initData;
  pis_word_type txWord;
  pis_word_type expQ[$];
  int nMismatch = 0;
  int testsRun = 0;

  pis_init_sequencer #(.STAB_CYCLES(20), .OC1_CYCLES(20), .PME_CYCLES(20), .OC2_CYCLES(20),
    .SLOT_CYCLES(20)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .syncPulse(syncPulse),
    .syncMode(syncMode), .wordLen10(wordLen10), .lockUser(lockUser), .selfTestPass(selfTestPass),
    .initData(initData), .txValid(txValid), .txReady(txReady), .txWord(txWord),
    .outputSilent(outputSilent), .progMode(progMode), .phase2Active(phase2Active),
    .normalMode(normalMode), .phase2Words(phase2Words));

  pis_receiver_model u_rx (.ref_clk(ref_clk), .rstn(rstn), .syncOn(syncOn), .stallLen(stallLen),
    .syncPulse(syncPulse), .txValid(txValid), .txReady(txReady), .txWord(txWord));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic finalReport();
    $display("Comparisons %0d, mismatches %0d", testsRun, nMismatch);
    if (nMismatch == 0 && testsRun > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finalReport

  // Reset for 10 cycles with the new configuration applied
  task automatic startRun(input logic sm, input logic src, input logic w10, input logic lk,
                          input logic sp, input int stall);
    @(posedge ref_clk);
    #1;
    rstn = 1'b0;
    syncMode = sm;
    syncOn = src;
    wordLen10 = w10;
    lockUser = lk;
    selfTestPass = sp;
    stallLen = 16'(stall);
    u_rx.got.delete();
    repeat (10) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
  endtask : startRun

  // Phase 1 takes 80 cycles; look at the first 76
  task automatic phase1Check();
    logic sawTx;
    logic sawLeave;
    sawTx = 1'b0;
    sawLeave = 1'b0;
    repeat (76) begin
      @(posedge ref_clk);
      #1;
      sawTx = sawTx | txValid;
      sawLeave = sawLeave | ~outputSilent | phase2Active | progMode;
    end
    check(sawTx, 1'b0);
    check(sawLeave, 1'b0);
  endtask : phase1Check

  task automatic buildExp(input logic w10, input int k, input logic pass);
    logic [3:0] nib;
    expQ.delete();
    for (int f = 0; f < (w10 ? 32 : 9); f++) begin
      nib = initData[4*f +: 4];
      if (w10) begin
        repeat (k) begin
          expQ.push_back(pis_word_type'({KIND_ID, ID_BASE_10 + 10'(f[3:0])}));
          expQ.push_back(pis_word_type'({KIND_DATA, DATA_BASE_10 + 10'(nib)}));
        end
      end else begin
        for (int h = 0; h < 2; h++) begin
          repeat (k) begin
            expQ.push_back(pis_word_type'({KIND_ID, 2'h0, ID_BASE_8 + 8'({f[0], h[0]})}));
            expQ.push_back(pis_word_type'({KIND_DATA, 2'h0, DATA_BASE_8 + 8'(h ? nib[1:0] : nib[3:2])}));
          end
        end
      end
    end
    expQ.push_back(pis_word_type'({KIND_STATUS, w10 ? BUSY_10 : {2'h0, BUSY_8}}));
    expQ.push_back(pis_word_type'({KIND_STATUS, w10 ? (pass ? READY_10 : DEFECT_10)
      : {2'h0, pass ? READY_8 : DEFECT_8}}));
  endtask : buildExp

  // Whole power-up run: phase 1, stream, phase 2 length
  task automatic runStream(input int words, input int durMin, input int durMax);
    int n;
    int dur;
    n = 0;
    dur = 0;
    phase1Check();
    check(phase2Words, words);
    while (!(normalMode === 1'b1 && u_rx.got.size() >= expQ.size()) && n < 30000) begin
      @(posedge ref_clk);
      #1;
      n++;
      dur += (phase2Active === 1'b1) ? 1 : 0;
    end
    if (n >= 30000) begin
      nMismatch++;
      $display("Timeout waiting for the end of initialization");
      finalReport();
    end
    check(u_rx.got.size(), expQ.size());
    foreach (expQ[i]) begin
      if (i < u_rx.got.size()) begin
        check(u_rx.got[i], expQ[i]);
      end
    end
    check(dur >= durMin && dur <= durMax, 1'b1);
  endtask : runStream

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic testAsync10();
    startRun(1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 0);
    buildExp(1'b1, 8, 1'b1);
    runStream(512, 511 * 20 - 4, 513 * 20 + 4);
    $display("Test async 10-bit done");
  endtask : testAsync10

  // Entry pulses arrive but the lock holds the device in init
  task automatic testSyncLocked10();
    startRun(1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 0);
    buildExp(1'b1, 4, 1'b0);
    runStream(256, 255 * 4 - 4, 257 * 4 + 4);
    check(progMode, 1'b0);
    $display("Test sync locked 10-bit done");
  endtask : testSyncLocked10

  // Long stall at the first word fills the FIFO
  task automatic testAsync8Stall();
    startRun(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 400);
    buildExp(1'b0, 8, 1'b1);
    runStream(288, 0, 30000);
    $display("Test async 8-bit stalled done");
  endtask : testAsync8Stall

  task automatic testProgEntry();
    logic sawTx;
    sawTx = 1'b0;
    startRun(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 0);
    repeat (300) begin
      @(posedge ref_clk);
      #1;
      sawTx = sawTx | txValid;
    end
    check(progMode, 1'b1);
    check(outputSilent, 1'b1);
    check(sawTx, 1'b0);
    check(phase2Active, 1'b0);
    $display("Test programming entry done");
  endtask : testProgEntry

  initial begin
    rstn = 1'b0;
    syncMode = 1'b0;
    syncOn = 1'b0;
    wordLen10 = 1'b1;
    lockUser = 1'b0;
    selfTestPass = 1'b1;
    stallLen = 16'h0000;
    initData = 128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210;
    testAsync10();
    testSyncLocked10();
    testAsync8Stall();
    testProgEntry();
    finalReport();
  end
endmodule : pis_init_sequencer_test

// ===== pis_pkg.sv
// Constants and types of the PSI5 init sequencer
package pis_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int ASYNC_PERIOD_NS = 228_000;
  localparam int ASYNC_PERIOD_CYC = ASYNC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int STAB_TIME_US = 1000;
  localparam int OC1_TIME_US = 1000;
  localparam int PME_TIME_US = 1000;
  localparam int OC2_TIME_US = 1000;
  localparam int STAB_CYC = STAB_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int OC1_CYC = OC1_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PME_CYC = PME_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int OC2_CYC = OC2_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PME_PULSES = 4;
  // ----------------------------------------
  // Framing
  // ----------------------------------------
  localparam logic [3:0] K_ASYNC = 4'h8;
  localparam logic [3:0] K_SYNC = 4'h4;
  localparam logic [5:0] FIELDS_10 = 6'h20;
  localparam logic [5:0] FIELDS_8 = 6'h09;
  localparam logic [2:0] TRANS_10 = 3'h2;
  localparam logic [2:0] TRANS_8 = 3'h4;
  // ----------------------------------------
  // Word codes
  // ----------------------------------------
  localparam logic [9:0] ID_BASE_10 = 10'h200;
  localparam logic [9:0] DATA_BASE_10 = 10'h210;
  localparam logic [9:0] BUSY_10 = 10'h1E8;
  localparam logic [9:0] READY_10 = 10'h1E7;
  localparam logic [9:0] DEFECT_10 = 10'h1F4;
  localparam logic [7:0] ID_BASE_8 = 8'h80;
  localparam logic [7:0] DATA_BASE_8 = 8'h84;
  localparam logic [7:0] BUSY_8 = 8'h7C;
  localparam logic [7:0] READY_8 = 8'h7B;
  localparam logic [7:0] DEFECT_8 = 8'h7D;
  typedef enum logic [3:0] {
    ST_STAB = 4'h0, ST_OC1 = 4'h1, ST_PME = 4'h2, ST_OC2 = 4'h3,
    ST_PROG = 4'h4, ST_PH2 = 4'h5, ST_BUSY = 4'h6, ST_RESULT = 4'h7,
    ST_NORMAL = 4'h8
  } pis_state_type;
  typedef struct packed {
    logic [1:0] kind;
    logic [9:0] code;
  } pis_word_type;
  localparam logic [1:0] KIND_ID = 2'h0;
  localparam logic [1:0] KIND_DATA = 2'h1;
  localparam logic [1:0] KIND_STATUS = 2'h2;
endpackage : pis_pkg

// ===== pis_receiver_model.sv
// Receiver-side model: sync pulse source and word sink
`timescale 1ns/10ps

module pis_receiver_model import pis_pkg::*; (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Test control
  input wire logic syncOn,
  input wire logic [15:0] stallLen,
  // Link to the sensor
  output logic syncPulse,
  input wire logic txValid,
  output logic txReady,
  input wire pis_word_type txWord
);
  pis_word_type got[$];
  logic [1:0] syncPh;
  logic seenValid;
  logic rstnSeen;
  int stallCnt;

  // Reset is taken at the edge, clear of the bench driving it 1 ns later
  always @(posedge ref_clk) begin
    rstnSeen = rstn;
    if (txValid === 1'b1 && txReady === 1'b1) begin
      got.push_back(txWord);
    end
    #1;
    if (rstnSeen !== 1'b1) begin
      syncPh = 2'h0;
      seenValid = 1'b0;
      stallCnt = 0;
    end else begin
      syncPh = syncPh + 2'h1;
    end
    syncPulse = syncOn & syncPh[1];
    // Slow answer: hold off the first word for stallLen cycles
    if (txValid === 1'b1) begin
      seenValid = 1'b1;
    end
    if (seenValid && stallCnt < int'(stallLen)) begin
      stallCnt++;
    end
    txReady = seenValid && stallCnt >= int'(stallLen);
  end
endmodule : pis_receiver_model
